// ===== gmhp_pkg.sv
/*
 * Shared constants and types of the generic micro host port:
 * host pin bundles, the control FSM states and the AXI4-Lite map.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package gmhp_pkg;

   // ==========================================================
   // Host port geometry
   localparam int ADDR_W    = 10;
   localparam int MEM_DEPTH = 1024;

   // ==========================================================
   // AXI4-Lite register byte offsets
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_INT_EN   = 12'h004;
   localparam logic [11:0] OFS_INT_PEND = 12'h008;
   localparam logic [11:0] OFS_STATUS   = 12'h00c;

   // Field positions
   localparam int CTRL_DRIVE_HIGH_BIT = 0;
   localparam int STAT_STATE_LSB      = 0;
   localparam int STAT_MODE_BIT       = 4;
   localparam int STAT_WIDTH_BIT      = 5;
   localparam int STAT_ADDR_LSB       = 16;

   // Values after reset
   localparam logic        DRIVE_HIGH_RST = 1'b0;
   localparam logic [15:0] INT_EN_RST     = 16'h0000;
   localparam logic [15:0] INT_PEND_RST   = 16'h0000;
   localparam logic [15:0] WORD_RST       = 16'h0000;
   localparam logic [10:0] ADDR_LAT_RST   = 11'h000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_RFETCH = 4'h2,
      ST_RDRIVE = 4'h4,
      ST_WHOLD  = 4'h8
   } gmhp_state_t;

   typedef struct packed {
      logic              cs_n;
      logic              data_strobe_n;  // Read strobe in separate-strobe mode
      logic              wr_rw_n;        // Write strobe, or read-high/write-low
      logic              addr_latch_en;
      logic              half_exchange;  // Address LSB in 8-bit mode
      logic [ADDR_W-1:0] addr_hi;
      logic [15:0]       d_i;
   } gmhp_pin_in_t;

   typedef struct packed {
      logic [15:0] d_o;
      logic [1:0]  d_oe;   // Bit 0 low lane, bit 1 high lane
      logic        rdy_n;
      logic        rdy_oe;
      logic        int_n;
      logic        int_oe;
   } gmhp_pin_out_t;

   localparam gmhp_pin_out_t PIN_OUT_RST = '{d_o: 16'h0000, d_oe: 2'h0, rdy_n: 1'b1,
                                             rdy_oe: 1'b0, int_n: 1'b1, int_oe: 1'b0};

endpackage

// ===== gmhp_regmem.sv
/*
 * Register bank behind the host port: one 16-bit word per address,
 * byte-lane write enables, read data from a register.
 * Assumes a single clock and the shared synchronous reset.
 */
`timescale 1ns/1ps
module gmhp_regmem import gmhp_pkg::*; (
   // Clock and control
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // Access port
   input  wire logic              we,
   input  wire logic [1:0]        be,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       wdata,
   output logic      [15:0]       rdata
);

   logic [15:0] mem [MEM_DEPTH];

   // Reset clears every word; costs area, but no stale value survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= WORD_RST;
         end
         rdata <= WORD_RST;
      end else if (ce) begin
         if (we && be[0]) begin
            mem[addr][7:0] <= wdata[7:0];
         end
         if (we && be[1]) begin
            mem[addr][15:8] <= wdata[15:8];
         end
         rdata <= mem[addr];  // Old value on a colliding write
      end
   end

endmodule

// ===== gmhp_lanes.sv
/*
 * Byte-lane steering between a 16-bit register word and the host
 * data pins, for both bus widths and the half exchange.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module gmhp_lanes import gmhp_pkg::*; (
   // Configuration
   input  wire logic        wide,
   input  wire logic        lsb,
   // Read path
   input  wire logic [15:0] rword,
   output logic      [15:0] pin_word,
   output logic      [1:0]  pin_en,
   // Write path
   input  wire logic [15:0] pin_data,
   output logic      [15:0] wword,
   output logic      [1:0]  wbe
);

   // 8-bit mode: one byte on the low lane; 16-bit: optional exchange
   always_comb begin
      if (!wide) begin
         pin_word = {8'h00, (lsb ? rword[15:8] : rword[7:0])};
         pin_en   = 2'h1;
         wword    = {pin_data[7:0], pin_data[7:0]};
         wbe      = lsb ? 2'h2 : 2'h1;
      end else if (lsb) begin
         pin_word = {rword[7:0], rword[15:8]};
         pin_en   = 2'h3;
         wword    = {pin_data[7:0], pin_data[15:8]};
         wbe      = 2'h3;
      end else begin
         pin_word = rword;
         pin_en   = 2'h3;
         wword    = pin_data;
         wbe      = 2'h3;
      end
   end

endmodule

// ===== gmhp_host_port.sv
/*
 * Generic 8/16-bit host processor port: strobes, address latch,
 * lane steering, ready handshake and interrupt pin, plus an AXI4-Lite
 * slave for the interrupt enables and pin options.
 * Assumes host pins already synchronous to aclk; pads resolve the
 * three-state pins from the output enables.
 */
`timescale 1ns/1ps
// Function
// - Data bus released in reset or deselect
// - Upper data lanes never driven in 8-bit
// - Upper address bits pick one register word
// - 8-bit mode: address LSB picks byte
// - 16-bit mode: LSB pin swaps the lanes
// - Address transparent while latch enable high
// - Mode select high means data strobe
// - Width select high means 16-bit bus
// - Ready low while cycle proceeds, else high
// - Ready undriven when not selected
// - Interrupt low on any enabled pending event
// - Idle interrupt drives high or floats, float default
// - Reset floats interrupt, disables all sources
// - Reset clears all registers and logic
module gmhp_host_port import gmhp_pkg::*; (
   // Clock, reset, enable
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   // Straps
   input  wire logic          mode_sel,
   input  wire logic          width_sel,
   // Host pins
   input  wire gmhp_pin_in_t  pin_i,
   output gmhp_pin_out_t      pin_o,
   // Interrupt events from the core
   input  wire logic [15:0]   int_event,
   // AXI4-Lite write
   input  wire logic [11:0]   s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0]   s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);

   // ==========================================================
   // Host side state
   gmhp_state_t   state_reg, state_next;
   logic [10:0]   addr_lat_reg, addr_lat_next;
   logic          wr_prev_reg, wr_prev_next;
   logic [15:0]   wd_reg, wd_next;
   gmhp_pin_out_t pin_o_reg, pin_o_next;
   logic [10:0]   addr_eff;
   logic          rd_act, wr_act, wr_commit, irq;
   logic [15:0]   mem_rdata, lane_rd, lane_wr;
   logic [1:0]    lane_en, lane_be;

   // ==========================================================
   // Config / AXI state
   logic          drive_high_reg, drive_high_next;
   logic [15:0]   int_en_reg, int_en_next;
   logic [15:0]   int_pend_reg, int_pend_next;
   logic          aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic [11:0]   awaddr_reg, awaddr_next;
   logic [31:0]   wdat_reg, wdat_next;
   logic [3:0]    wstrb_reg, wstrb_next;
   logic          awready_reg, awready_next, wready_reg, wready_next;
   logic          bvalid_reg, bvalid_next, arready_reg, arready_next;
   logic          rvalid_reg, rvalid_next;
   logic [1:0]    bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0]   rdata_reg, rdata_next;
   logic [15:0]   pend_clr;

   // Apply the two low AXI byte strobes to a 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {(s[1] ? d[15:8] : old[15:8]), (s[0] ? d[7:0] : old[7:0])};
   endfunction

   // ==========================================================
   // Submodules
   gmhp_regmem u_mem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .we      (wr_commit),
      .be      (lane_be),
      .addr    (addr_eff[10:1]),
      .wdata   (lane_wr),
      .rdata   (mem_rdata)
   );

   gmhp_lanes u_lanes (
      .wide     (width_sel),
      .lsb      (addr_eff[0]),
      .rword    (mem_rdata),
      .pin_word (lane_rd),
      .pin_en   (lane_en),
      .pin_data (wd_reg),
      .wword    (lane_wr),
      .wbe      (lane_be)
   );

   // ==========================================================
   // Host cycle decode, FSM and pin drivers
   always_comb begin
      // Transparent while latch enable high, held once it falls
      addr_lat_next = pin_i.addr_latch_en ? {pin_i.addr_hi, pin_i.half_exchange}
                                          : addr_lat_reg;
      addr_eff = pin_i.addr_latch_en ? {pin_i.addr_hi, pin_i.half_exchange} : addr_lat_reg;
      // Strobe style picked by the mode strap
      if (mode_sel) begin
         rd_act = !pin_i.cs_n && !pin_i.data_strobe_n && pin_i.wr_rw_n;
         wr_act = !pin_i.cs_n && !pin_i.data_strobe_n && !pin_i.wr_rw_n;
      end else begin
         rd_act = !pin_i.cs_n && !pin_i.data_strobe_n;
         wr_act = !pin_i.cs_n && !pin_i.wr_rw_n;
      end
      wr_prev_next = wr_act;
      // Data is taken while the strobe is low, so a late pin change is harmless
      wd_next   = wr_act ? pin_i.d_i : wd_reg;
      wr_commit = wr_prev_reg && !wr_act && !pin_i.cs_n;
      irq       = |(int_pend_reg & int_en_reg);
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (rd_act) begin
               state_next = ST_RFETCH;
            end else if (wr_act) begin
               state_next = ST_WHOLD;
            end
         end
         ST_RFETCH: begin
            state_next = rd_act ? ST_RDRIVE : ST_IDLE;
         end
         ST_RDRIVE: begin
            if (!rd_act) begin
               state_next = ST_IDLE;
            end
         end
         ST_WHOLD: begin
            if (!wr_act) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      pin_o_next.d_o = lane_rd;
      // Only a selected read in progress drives; upper lane only when wide
      pin_o_next.d_oe = (state_next == ST_RDRIVE) ? lane_en : 2'h0;
      pin_o_next.rdy_oe = !pin_i.cs_n;
      pin_o_next.rdy_n = !((state_next == ST_RDRIVE) || (state_next == ST_WHOLD));
      pin_o_next.int_n = !irq;
      pin_o_next.int_oe = irq || drive_high_reg;
   end

   // Host side registers, all cleared by reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= ST_IDLE;
         addr_lat_reg <= ADDR_LAT_RST;
         wr_prev_reg  <= 1'b0;
         wd_reg       <= WORD_RST;
         pin_o_reg    <= PIN_OUT_RST;
      end else if (ce) begin
         state_reg    <= state_next;
         addr_lat_reg <= addr_lat_next;
         wr_prev_reg  <= wr_prev_next;
         wd_reg       <= wd_next;
         pin_o_reg    <= pin_o_next;
      end
   end

   assign pin_o = pin_o_reg;

   // ==========================================================
   // AXI4-Lite slave and interrupt bookkeeping
   always_comb begin
      drive_high_next = drive_high_reg;
      int_en_next     = int_en_reg;
      aw_full_next    = aw_full_reg;
      w_full_next     = w_full_reg;
      awaddr_next     = awaddr_reg;
      wdat_next       = wdat_reg;
      wstrb_next      = wstrb_reg;
      awready_next    = awready_reg;
      wready_next     = wready_reg;
      bvalid_next     = bvalid_reg;
      bresp_next      = bresp_reg;
      arready_next    = arready_reg;
      rvalid_next     = rvalid_reg;
      rresp_next      = rresp_reg;
      rdata_next      = rdata_reg;
      pend_clr        = 16'h0000;
      // Address and data are taken independently, in either order
      if (s_axi_awvalid && awready_reg) begin
         aw_full_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
         awready_next = 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_full_next = 1'b1;
         wdat_next   = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
         wready_next = 1'b0;
      end
      if (aw_full_reg && w_full_reg && !bvalid_reg) begin
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = RESP_OKAY;
         if (awaddr_reg == OFS_CTRL) begin
            if (wstrb_reg[0]) begin
               drive_high_next = wdat_reg[CTRL_DRIVE_HIGH_BIT];
            end
         end else if (awaddr_reg == OFS_INT_EN) begin
            int_en_next = merge16(int_en_reg, wdat_reg, wstrb_reg);
         end else if (awaddr_reg == OFS_INT_PEND) begin
            pend_clr = merge16(16'h0000, wdat_reg, wstrb_reg);
         end else if (awaddr_reg != OFS_STATUS) begin
            bresp_next = RESP_SLVERR;
         end
      end
      // Channels reopen only after the response, one write at a time
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next  = 1'b0;
         awready_next = 1'b1;
         wready_next  = 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next  = 1'b1;
         rresp_next   = RESP_OKAY;
         rdata_next   = 32'h0000_0000;
         if (s_axi_araddr == OFS_CTRL) begin
            rdata_next[CTRL_DRIVE_HIGH_BIT] = drive_high_reg;
         end else if (s_axi_araddr == OFS_INT_EN) begin
            rdata_next[15:0] = int_en_reg;
         end else if (s_axi_araddr == OFS_INT_PEND) begin
            rdata_next[15:0] = int_pend_reg;
         end else if (s_axi_araddr == OFS_STATUS) begin
            rdata_next[STAT_STATE_LSB+:4]  = state_reg;
            rdata_next[STAT_MODE_BIT]      = mode_sel;
            rdata_next[STAT_WIDTH_BIT]     = width_sel;
            rdata_next[STAT_ADDR_LSB+:11]  = addr_lat_reg;
         end else begin
            rresp_next = RESP_SLVERR;
         end
      end
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next  = 1'b0;
         arready_next = 1'b1;
      end
      // A new event beats a clear in the same cycle
      int_pend_next = (int_pend_reg & ~pend_clr) | int_event;
   end

   // Sources come out of reset disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_high_reg <= DRIVE_HIGH_RST;
         int_en_reg     <= INT_EN_RST;
         int_pend_reg   <= INT_PEND_RST;
         aw_full_reg    <= 1'b0;
         w_full_reg     <= 1'b0;
         awaddr_reg     <= 12'h000;
         wdat_reg       <= 32'h0000_0000;
         wstrb_reg      <= 4'h0;
         awready_reg    <= 1'b1;
         wready_reg     <= 1'b1;
         bvalid_reg     <= 1'b0;
         bresp_reg      <= RESP_OKAY;
         arready_reg    <= 1'b1;
         rvalid_reg     <= 1'b0;
         rresp_reg      <= RESP_OKAY;
         rdata_reg      <= 32'h0000_0000;
      end else if (ce) begin
         drive_high_reg <= drive_high_next;
         int_en_reg     <= int_en_next;
         int_pend_reg   <= int_pend_next;
         aw_full_reg    <= aw_full_next;
         w_full_reg     <= w_full_next;
         awaddr_reg     <= awaddr_next;
         wdat_reg       <= wdat_next;
         wstrb_reg      <= wstrb_next;
         awready_reg    <= awready_next;
         wready_reg     <= wready_next;
         bvalid_reg     <= bvalid_next;
         bresp_reg      <= bresp_next;
         arready_reg    <= arready_next;
         rvalid_reg     <= rvalid_next;
         rresp_reg      <= rresp_next;
         rdata_reg      <= rdata_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_write_end;
      ce && wr_act ##1 ce && !wr_act && !pin_i.cs_n;
   endsequence

   chk_bus_released: assert property (ce && pin_i.cs_n |=> pin_o.d_oe == 2'h0)
      else $error("data driven while deselected");
   chk_upper_quiet: assert property (ce && !width_sel |=> !pin_o.d_oe[1])
      else $error("upper lane driven in 8-bit mode");
   chk_byte_pick: assert property (ce && state_reg == ST_RFETCH && rd_act && !width_sel
         |=> pin_o.d_oe == 2'h1 && pin_o.d_o[7:0] ==
             ($past(addr_eff[0]) ? $past(mem_rdata[15:8]) : $past(mem_rdata[7:0])))
      else $error("wrong byte on low lane");
   chk_swap_lanes: assert property (ce && state_reg == ST_RFETCH && rd_act && width_sel
         && addr_eff[0] |=> pin_o.d_o == {$past(mem_rdata[7:0]), $past(mem_rdata[15:8])})
      else $error("lanes not exchanged");
   chk_addr_hold: assert property (ce && !pin_i.addr_latch_en |=>
         addr_lat_reg == $past(addr_lat_reg))
      else $error("latched address moved");
   chk_ready_drive: assert property (ce && !pin_i.cs_n && rd_act && state_reg == ST_IDLE
         |=> pin_o.rdy_oe && pin_o.rdy_n ##1 !$past(ce) || !$past(rd_act) || !pin_o.rdy_n)
      else $error("ready sequence wrong on read");
   chk_ready_float: assert property (ce && pin_i.cs_n |=> !pin_o.rdy_oe)
      else $error("ready driven while deselected");
   chk_int_assert: assert property (ce && |(int_pend_reg & int_en_reg)
         |=> pin_o.int_oe && !pin_o.int_n)
      else $error("interrupt not asserted");
   chk_int_idle: assert property (ce && !(|(int_pend_reg & int_en_reg))
         |=> pin_o.int_n && pin_o.int_oe == $past(drive_high_reg))
      else $error("idle interrupt level wrong");
   chk_reset_float: assert property ($rose(aresetn) |-> !pin_o.int_oe
         && int_en_reg == 16'h0000)
      else $error("interrupt live after reset");
   chk_write_commit: assert property (s_write_end |-> wr_commit)
      else $error("write not committed at strobe end");

endmodule

// ===== gmhp_host_model.sv
/* Host processor model for the host port: drives the pins,
   reads and writes one word per call, one byte in 8-bit mode. Assumes straps stable. */
`timescale 1ns/1ps
module gmhp_host_model import gmhp_pkg::*; (
   // Clock and options
   input  wire logic    aclk,
   input  wire logic    mode_sel,
   input  wire logic    use_ale,
   // Pins
   input  wire gmhp_pin_out_t pin_o,
   output gmhp_pin_in_t  pin_i,
   // Read result
   output logic          rd_done,
   output logic [17:0]   rd_val
);
   // ==========================================
   // Idle pins: data lines float to the pull-ups
   initial begin
      pin_i = '{cs_n: 1'b1, data_strobe_n: 1'b1, wr_rw_n: 1'b1, addr_latch_en: 1'b1,
                half_exchange: 1'b0, addr_hi: '0, d_i: 16'hffff};
      rd_done = 1'b0;
      rd_val = '0;
   end
   // One access; the wait is cut short by the bench timeout
   task automatic go(input logic wr, input logic [10:0] a, input logic [15:0] d);
      begin
         @(posedge aclk);
         pin_i.addr_hi <= {1'b0, a[9:1]};
         pin_i.half_exchange <= a[0];
         pin_i.addr_latch_en <= 1'b1;
         if (use_ale) begin
            // Multiplexed host: latch, then scramble the pins
            @(posedge aclk);
            pin_i.addr_latch_en <= 1'b0;
            @(posedge aclk);
            pin_i.addr_hi <= ~{1'b0, a[9:1]};
         end
         pin_i.cs_n <= 1'b0;
         pin_i.d_i <= wr ? d : 16'hffff;
         pin_i.data_strobe_n <= wr && !mode_sel;
         pin_i.wr_rw_n <= !wr;
         do @(posedge aclk);
         while (!(pin_o.rdy_oe && !pin_o.rdy_n && (wr || pin_o.d_oe != 2'h0)));
         rd_val <= {pin_o.d_oe, pin_o.d_o & {{8{pin_o.d_oe[1]}}, {8{pin_o.d_oe[0]}}}};
         rd_done <= !wr;
         pin_i.data_strobe_n <= 1'b1;
         pin_i.wr_rw_n <= 1'b1;
         pin_i.d_i <= 16'hffff;
         // Select stays low one more edge so the write lands
         @(posedge aclk);
         rd_done <= 1'b0;
         pin_i.cs_n <= 1'b1;
      end
   endtask
endmodule

// ===== gmhp_host_port_test.sv
/* Self-checking bench of the host port: host model on the pins,
   AXI4-Lite master tasks, queue of expected results. */
`timescale 1ns/1ps
module gmhp_host_port_test import gmhp_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, mode_sel = 1'b0, width_sel = 1'b0, use_ale = 1'b0;
   logic [15:0] int_event = '0;
   gmhp_pin_in_t pin_i;
   gmhp_pin_out_t pin_o;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
   logic arvalid = 0, arready, rvalid, rready = 0;
   logic [1:0] bresp, rresp;
   logic rd_done;
   logic [17:0] rd_val;
   logic [33:0] q[$];
   int mismatches = 0, compares = 0, cycles = 0;
   logic [10:0] a;
   logic [15:0] r, word;
   logic s;

   always #2.5 aclk = ~aclk;
   gmhp_host_port DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .mode_sel(mode_sel),
      .width_sel(width_sel), .pin_i(pin_i), .pin_o(pin_o), .int_event(int_event),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   gmhp_host_model host (.aclk(aclk), .mode_sel(mode_sel), .use_ale(use_ale),
      .pin_o(pin_o), .pin_i(pin_i), .rd_done(rd_done), .rd_val(rd_val));

   // ==========================================
   // Checking
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic take(input logic [33:0] seen);
      logic [33:0] e;
      e = q.size() ? q.pop_front() : 'x;
      check(seen, e);
   endtask
   // Results are matched in the order they were requested
   always @(posedge aclk) begin
      if (bvalid && bready) take({bresp, 32'h0});
      if (rvalid && rready) take({rresp, rdata});
      if (rd_done) take({16'h0, rd_val});
   end
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // A hang counts as a failure
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report;
      end
   end

   // ==========================================
   // AXI4-Lite master
   task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      q.push_back({er, 32'h0});
      @(posedge aclk);
      awaddr <= ad; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
         if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
      end while (!(aw_ok && w_ok));
      while (!bvalid) @(posedge aclk);
      bready <= 0;
   endtask
   task automatic axi_rd(input logic [11:0] ad, input logic [33:0] e);
      q.push_back(e);
      @(posedge aclk);
      araddr <= ad; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 0;
   endtask
   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      // Pins released after reset, outside any access
      check({30'h0, pin_o.d_oe, pin_o.rdy_oe, pin_o.int_oe}, 34'h0);
   endtask
   task automatic ev(input logic [15:0] v, input logic [1:0] pin);
      @(posedge aclk);
      int_event <= v;
      @(posedge aclk);
      int_event <= '0;
      repeat (3) @(posedge aclk);
      check({32'h0, pin_o.int_oe, pin_o.int_n}, {32'h0, pin});
   endtask

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(62));
      do_reset;
      // Every strobe mode and bus width; data-strobe mode multiplexes
      for (int m = 0; m < 2; m++) for (int w = 0; w < 2; w++) repeat (2) begin
         @(posedge aclk);
         mode_sel <= m[0]; width_sel <= w[0]; use_ale <= m[0];
         a = 11'($urandom) & 11'h3fe;
         r = 16'($urandom);
         s = 1'($urandom);
         if (w) begin
            host.go(1, a | 11'(s), r);
            word = s ? {r[7:0], r[15:8]} : r;
         end else begin
            host.go(1, a, {8'hff, r[7:0]});
            host.go(1, a | 11'h1, {8'hff, r[15:8]});
            word = r;
         end
         for (int k = 0; k < 2; k++) begin
            q.push_back(w ? {16'h0, 2'h3, k ? {word[7:0], word[15:8]} : word}
                          : {16'h0, 2'h1, 8'h0, k ? word[15:8] : word[7:0]});
            host.go(0, a | 11'(k), 16'h0);
         end
         $display("test host mode %0d width %0d done", m, w);
      end
      // Latched address of the last multiplexed access, straps and idle state
      axi_rd(OFS_STATUS, {RESP_OKAY, 5'h0, a | 11'h1, 10'h0, 2'b11, ST_IDLE});
      // Interrupt pin: enabled, cleared, drive-high option, disabled source
      axi_wr(OFS_INT_EN, 32'h4, RESP_OKAY);
      ev(16'h0004, 2'b10);
      axi_wr(OFS_INT_PEND, 32'h4, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check({33'h0, pin_o.int_oe}, 34'h0);
      axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
      // Clock enable low: an event pulse must leave no pending trace
      ce <= 1'b0;
      ev(16'h0004, 2'b11);
      ce <= 1'b1;
      ev(16'h0020, 2'b11);
      axi_rd(OFS_INT_EN, {RESP_OKAY, 32'h4});
      axi_wr(12'h100, 32'h1, RESP_SLVERR);
      axi_rd(12'h100, {RESP_SLVERR, 32'h0});
      $display("test interrupt done");
      // Mid-run reset clears enables and the drive option
      do_reset;
      axi_rd(OFS_INT_EN, {RESP_OKAY, 32'h0});
      axi_rd(OFS_CTRL, {RESP_OKAY, 32'h0});
      $display("test reset done");
      repeat (3) @(posedge aclk);
      check(34'(q.size()), 34'h0);
      final_report;
   end
endmodule
